/* hw/mem_ctrl_pkg.sv */
/*
  Package for the memory controller remap and abort status block:
  register offsets, field positions, reset values and access encodings.
  Assumes a 32-bit register port with byte offsets.
*/
package mem_ctrl_pkg;
  localparam logic [7:0] REMAP_CONTROL_OFS = 8'h00;
  localparam logic [7:0] ABORT_STATUS_OFS = 8'h04;
  localparam logic [7:0] ABORT_ADDRESS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] REMAP_STATE_OFS = 8'h14;

  localparam int REMAP_TOGGLE_POS = 0;
  localparam int UNDEF_POS = 0;
  localparam int MISALIGN_POS = 1;
  localparam int SIZE_LO_POS = 8;
  localparam int TYPE_LO_POS = 10;
  localparam int DMA_LAST_POS = 16;
  localparam int CPU_LAST_POS = 17;
  localparam int DMA_STICKY_POS = 24;
  localparam int CPU_STICKY_POS = 25;

  // interrupt status bits: dma abort, cpu abort
  localparam int IRQ_DMA_POS = 0;
  localparam int IRQ_CPU_POS = 1;

  localparam logic [31:0] ABORT_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ABORT_ADDRESS_RST = 32'h0000_0000;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] TYPE_READ = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_FETCH = 2'h2;

  localparam logic [3:0] INTERNAL_AREA = 4'h0;
  localparam logic [3:0] PERIPH_AREA = 4'hF;
  localparam logic [11:0] FLASH_MB = 12'h001;
  localparam logic [11:0] SRAM_MB = 12'h002;
  localparam logic [11:0] FREE_MB = 12'h003;
  localparam logic [11:0] PAGE0_MB = 12'h000;
endpackage

/* hw/memory_ctrl_remap_abort_regs.sv */
/*
  Remap control and abort status registers of the on-chip memory controller.
  Watches one bus access per cycle from the winning master (arbitration is
  outside), flags undefined and misaligned accesses, records the last abort
  and decodes which memory answers at page zero.
  Assumes synchronous inputs and a single-cycle register port.
*/
// Our own choice: the address-and-strobe port.
// How it works
// - writing one to remap bit zero toggles page-zero mapping; zero ignored
// - remap on shows SRAM at page zero, otherwise flash sits there
// - status bit zero set when last abort hit an undefined address
// - status bit one set when last abort was a misaligned access
// - abort misaligned word or half-word data access; fetches never alignment-checked
// - bits 9:8 record aborted access size: byte, half, word
// - bits 11:10 record aborted access kind: read, write, fetch
// - bit 16 marks last abort as issued by the DMA master
// - bit 17 marks last abort as issued by the processor
// - bit 24 sticky: at least one DMA abort occurred
// - bit 25 sticky: at least one processor abort occurred
// - reading abort status restarts sticky flag accumulation
// - abort address register at 0x08 holds full last aborted address
// - only first flash controller owns security and nonvolatile bits
`timescale 1ns/10ps
`default_nettype none
module memory_ctrl_remap_abort_regs
  import mem_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic acc_valid_in,
  input wire logic [31:0] acc_addr_in,
  input wire logic [1:0] acc_size_in,
  input wire logic [1:0] acc_type_in,
  input wire logic acc_dma_in,
  output logic acc_abort_out,
  output logic page0_sram_out,
  output logic [11:0] mapped_mb_out,
  output logic flash_sec_owner_out,
  output logic irq_out
);

  typedef struct packed {
    logic remap;
    logic [31:0] status;
    logic [31:0] abort_addr;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;

  logic undef_hit;
  logic misalign_hit;
  logic abort_now;
  logic [11:0] mb_sel;

  always_comb begin
    mb_sel = acc_addr_in[31:20] - {INTERNAL_AREA, 8'h00};
    misalign_hit = (acc_type_in != TYPE_FETCH) &&
                   (((acc_size_in == SIZE_WORD) && (acc_addr_in[1:0] != 2'h0)) ||
                    ((acc_size_in == SIZE_HALF) && acc_addr_in[0]));
    // internal area: page 0, flash, sram and a silent 1MB hole are defined
    undef_hit = !((acc_addr_in[31:28] == PERIPH_AREA) ||
                  ((acc_addr_in[31:28] == INTERNAL_AREA) && (mb_sel <= FREE_MB)));
    abort_now = acc_valid_in && (undef_hit || misalign_hit);
  end

  always_comb begin
    nxt_ff = cur_ff;
    if (reg_wr_in && (reg_addr_in == REMAP_CONTROL_OFS) &&
        reg_wdata_in[REMAP_TOGGLE_POS]) begin
      nxt_ff.remap = !cur_ff.remap;
    end
    if (reg_wr_in && (reg_addr_in == IRQ_MASK_OFS)) begin
      nxt_ff.irq_mask = reg_wdata_in[1:0];
    end
    if (reg_wr_in && (reg_addr_in == IRQ_STATUS_OFS)) begin
      nxt_ff.irq_status = cur_ff.irq_status & ~reg_wdata_in[1:0];
    end
    if (reg_rd_in && (reg_addr_in == ABORT_STATUS_OFS)) begin
      nxt_ff.status[DMA_STICKY_POS] = 1'b0;
      nxt_ff.status[CPU_STICKY_POS] = 1'b0;
    end
    // capture all fields at once; set wins over read clear
    if (abort_now) begin
      nxt_ff.status[UNDEF_POS] = undef_hit;
      nxt_ff.status[MISALIGN_POS] = misalign_hit;
      nxt_ff.status[SIZE_LO_POS +: 2] = acc_size_in;
      nxt_ff.status[TYPE_LO_POS +: 2] = acc_type_in;
      nxt_ff.status[DMA_LAST_POS] = acc_dma_in;
      nxt_ff.status[CPU_LAST_POS] = !acc_dma_in;
      if (acc_dma_in) begin
        nxt_ff.status[DMA_STICKY_POS] = 1'b1;
        nxt_ff.irq_status[IRQ_DMA_POS] = 1'b1;
      end else begin
        nxt_ff.status[CPU_STICKY_POS] = 1'b1;
        nxt_ff.irq_status[IRQ_CPU_POS] = 1'b1;
      end
      nxt_ff.abort_addr = acc_addr_in;
    end
    nxt_ff.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ABORT_STATUS_OFS: nxt_ff.rdata = cur_ff.status;
        ABORT_ADDRESS_OFS: nxt_ff.rdata = cur_ff.abort_addr;
        IRQ_STATUS_OFS: nxt_ff.rdata = {30'h0, cur_ff.irq_status};
        IRQ_MASK_OFS: nxt_ff.rdata = {30'h0, cur_ff.irq_mask};
        REMAP_STATE_OFS: nxt_ff.rdata = {31'h0, cur_ff.remap};
        default: nxt_ff.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_ff <= '{remap: 1'b0, status: ABORT_STATUS_RST,
                  abort_addr: ABORT_ADDRESS_RST, irq_status: 2'h0,
                  irq_mask: IRQ_MASK_RST, rdata: 32'h0000_0000};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign reg_rdata_out = cur_ff.rdata;
  // abort reply is combinational so the access is cancelled in its own cycle
  assign acc_abort_out = abort_now;
  assign page0_sram_out = cur_ff.remap;
  assign mapped_mb_out = (acc_addr_in[31:28] == INTERNAL_AREA) && (mb_sel == PAGE0_MB) ?
                         (cur_ff.remap ? SRAM_MB : FLASH_MB) : mb_sel;
  // single owner of the security bits
  assign flash_sec_owner_out = 1'b1;
  assign irq_out = |(cur_ff.irq_status & cur_ff.irq_mask);

  sequence s_remap_write;
    reg_wr_in && (reg_addr_in == REMAP_CONTROL_OFS) && reg_wdata_in[REMAP_TOGGLE_POS];
  endsequence

  sequence s_abort_dma;
    abort_now && acc_dma_in;
  endsequence

  a_remap_toggle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_remap_write |=> page0_sram_out != $past(page0_sram_out))
    else $error("remap did not toggle");
  a_remap_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(reg_wr_in && (reg_addr_in == REMAP_CONTROL_OFS) && reg_wdata_in[0]) |=> $stable(page0_sram_out))
    else $error("remap changed without command");
  a_page0_map: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (acc_addr_in[31:20] == 12'h000) |-> mapped_mb_out == (page0_sram_out ? SRAM_MB : FLASH_MB))
    else $error("page zero decode wrong");
  a_misalign_abort: assert property (@(posedge clk_in) disable iff (!resetn_in)
    acc_valid_in && acc_type_in != TYPE_FETCH && acc_size_in == SIZE_WORD &&
    acc_addr_in[1:0] != 2'h0 |-> acc_abort_out)
    else $error("misaligned word not aborted");
  a_fetch_unchecked: assert property (@(posedge clk_in) disable iff (!resetn_in)
    acc_valid_in && acc_type_in == TYPE_FETCH && acc_addr_in[31:20] == 12'h001
    |-> !acc_abort_out)
    else $error("fetch aborted for alignment");
  a_cause_flags: assert property (@(posedge clk_in) disable iff (!resetn_in)
    abort_now |=> cur_ff.status[MISALIGN_POS] == $past(misalign_hit))
    else $error("misalign flag wrong");
  a_undef_flag: assert property (@(posedge clk_in) disable iff (!resetn_in)
    abort_now |=> cur_ff.status[UNDEF_POS] == $past(undef_hit))
    else $error("undefined flag wrong");
  a_size_type: assert property (@(posedge clk_in) disable iff (!resetn_in)
    abort_now |=> cur_ff.status[11:8] == {$past(acc_type_in), $past(acc_size_in)})
    else $error("size or type not captured");
  a_dma_source: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_abort_dma |=> cur_ff.status[17:16] == 2'h1 && cur_ff.status[DMA_STICKY_POS])
    else $error("dma source wrong");
  a_cpu_source: assert property (@(posedge clk_in) disable iff (!resetn_in)
    abort_now && !acc_dma_in |=> cur_ff.status[17:16] == 2'h2 && cur_ff.status[CPU_STICKY_POS])
    else $error("cpu source wrong");
  a_sticky_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_rd_in && reg_addr_in == ABORT_STATUS_OFS && !abort_now
    |=> cur_ff.status[25:24] == 2'h0 ##0 reg_rdata_out == $past(cur_ff.status))
    else $error("sticky flags not restarted by read");
  a_addr_capture: assert property (@(posedge clk_in) disable iff (!resetn_in)
    abort_now |=> cur_ff.abort_addr == $past(acc_addr_in))
    else $error("abort address not captured");
  a_addr_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !abort_now |=> $stable(cur_ff.abort_addr) && $stable(cur_ff.status[17:0]))
    else $error("abort record changed without abort");
endmodule
`default_nettype wire

/* test/access_master_model.sv */
/*
  Model of the granted bus master driving the access port, one access a call.
  Assumes the bench calls issue from its main sequence.
*/
`timescale 1ns/10ps
`default_nettype none
module access_master_model (
  input wire logic clk_in,
  input wire logic acc_abort_in,
  input wire logic [11:0] mapped_mb_in,
  output logic acc_valid_out,
  output logic [31:0] acc_addr_out,
  output logic [1:0] acc_size_out,
  output logic [1:0] acc_type_out,
  output logic acc_dma_out
);
  initial begin
    acc_valid_out = 1'b0;
    acc_addr_out = 32'h0000_0000;
    acc_size_out = 2'h0;
    acc_type_out = 2'h0;
    acc_dma_out = 1'b0;
  end
  task automatic issue(input logic [31:0] a, input logic [1:0] s, input logic [1:0] t,
                       input logic d, output logic ab, output logic [11:0] mb);
    @(posedge clk_in);
    acc_valid_out <= 1'b1;
    acc_addr_out <= a;
    acc_size_out <= s;
    acc_type_out <= t;
    acc_dma_out <= d;
    #1;
    ab = acc_abort_in;
    mb = mapped_mb_in;
    @(posedge clk_in);
    // released bus shows junk, not the last address
    acc_valid_out <= 1'b0;
    acc_addr_out <= ~a;
    acc_dma_out <= ~d;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
/*
  Register and abort status bench: register port tasks plus an access master model.
  Assumes the 20 MHz clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mem_ctrl_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, acc_addr;
  logic acc_valid, acc_dma, abort_out, page0_sram_out, owner_out, irq_out, ab;
  logic [1:0] acc_size, acc_type;
  logic [11:0] mb_out, mb;
  logic [31:0] d;
  int fail_count = 0, cmp_count = 0, cycles = 0;
  memory_ctrl_remap_abort_regs u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .acc_valid_in(acc_valid),
    .acc_addr_in(acc_addr), .acc_size_in(acc_size), .acc_type_in(acc_type),
    .acc_dma_in(acc_dma), .acc_abort_out(abort_out), .page0_sram_out(page0_sram_out),
    .mapped_mb_out(mb_out), .flash_sec_owner_out(owner_out), .irq_out(irq_out));
  access_master_model u_master (.clk_in(clk_in), .acc_abort_in(abort_out),
    .mapped_mb_in(mb_out), .acc_valid_out(acc_valid),
    .acc_addr_out(acc_addr), .acc_size_out(acc_size), .acc_type_out(acc_type),
    .acc_dma_out(acc_dma));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    v = reg_rdata_out;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling well above the roughly fifty cycles the sequence needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(ABORT_STATUS_OFS, d); check("status reset", d, ABORT_STATUS_RST);
    rd(ABORT_ADDRESS_OFS, d); check("address reset", d, ABORT_ADDRESS_RST);
    check("owner", owner_out, 1'b1);
    rd(REMAP_CONTROL_OFS, d); check("remap wo", d, 32'h0);
    rd(8'h20, d); check("unmapped", d, 32'h0);
    wr(REMAP_CONTROL_OFS, 32'h0); check("remap zero", page0_sram_out, 1'b0);
    u_master.issue(32'h0, SIZE_BYTE, TYPE_READ, 1'b0, ab, mb); check("flash p0", mb, 12'h001);
    wr(REMAP_CONTROL_OFS, 32'h1); check("remap on", page0_sram_out, 1'b1);
    u_master.issue(32'h0, SIZE_BYTE, TYPE_READ, 1'b0, ab, mb); check("sram p0", mb, 12'h002);
    wr(REMAP_CONTROL_OFS, 32'h1); check("remap off", page0_sram_out, 1'b0);
    u_master.issue(32'h0010_0002, SIZE_WORD, TYPE_READ, 1'b0, ab, mb); check("misal", ab, 1'b1);
    rd(ABORT_STATUS_OFS, d); check("cpu stat", d, 32'h0202_0202);
    rd(ABORT_STATUS_OFS, d); check("sticky clr", d, 32'h0002_0202);
    rd(ABORT_ADDRESS_OFS, d); check("addr1", d, 32'h0010_0002);
    u_master.issue(32'h0010_0001, SIZE_HALF, TYPE_WRITE, 1'b1, ab, mb); check("half", ab, 1'b1);
    u_master.issue(32'h3000_0000, SIZE_HALF, TYPE_WRITE, 1'b1, ab, mb); check("undef", ab, 1'b1);
    rd(ABORT_STATUS_OFS, d); check("dma stat", d, 32'h0101_0501);
    rd(ABORT_ADDRESS_OFS, d); check("addr2", d, 32'h3000_0000);
    u_master.issue(32'h0000_0002, SIZE_WORD, TYPE_FETCH, 1'b0, ab, mb); check("fetch", ab, 1'b0);
    u_master.issue(32'h5000_0001, SIZE_WORD, TYPE_FETCH, 1'b0, ab, mb); check("fundef", ab, 1'b1);
    rd(ABORT_STATUS_OFS, d); check("fetch stat", d, 32'h0202_0A01);
    check("irq masked", irq_out, 1'b0);
    wr(IRQ_MASK_OFS, 32'h2); check("irq on", irq_out, 1'b1);
    wr(IRQ_STATUS_OFS, 32'h2); check("irq clr", irq_out, 1'b0);
    wr(IRQ_MASK_OFS, 32'h1); check("irq dma", irq_out, 1'b1);
    rd(IRQ_STATUS_OFS, d); check("irq stat", d, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
